// *** pkg/tsp_pkg.sv ***
// package for the two-wire slave register port
// assumes a single 25 MHz reference clock domain
package tsp_pkg;
   // ==========================================
   // bus identity and byte layout
   localparam logic [6:0] TSP_SLAVE_ADDR = 7'h33;
   localparam logic [4:0] TSP_HS_CODE_TOP = 5'h01;
   localparam int TSP_REG_NUM_W = 3;
   localparam int TSP_DATA_W = 8;
   localparam int TSP_BIT_CNT_W = 4;
   localparam logic [3:0] TSP_ACK_BIT = 4'h8;
   localparam logic [7:0] TSP_UNMAPPED_DATA = 8'h00;
   localparam logic [7:0] TSP_REG_RESET = 8'h00;
   // ==========================================
   // timing: 25 MHz reference clock
   localparam int TSP_CLK_NS = 40;
   localparam int TSP_SYNC_STAGES = 2;
   // ==========================================
   // receiver states
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_ADDR = 6'b000010,
      ST_REG = 6'b000100,
      ST_WDATA = 6'b001000,
      ST_RDATA = 6'b010000,
      ST_IGNORE = 6'b100000
   } tsp_state_t;
endpackage

// *** pkg/tsp_line_if.sv ***
// interface carrying synchronised line events between the modules
// assumes both ends run on the same reference clock
interface tsp_line_if;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   modport src (output scl_s, sda_s, scl_rise, scl_fall, start_det,
      stop_det);
   modport dst (input scl_s, sda_s, scl_rise, scl_fall, start_det,
      stop_det);
endinterface

// *** core/tsp_line_sync.sv ***
// two-flop synchroniser and edge finder for the serial lines
// assumes the lines come straight from pins, unrelated to the clock
module tsp_line_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   tsp_line_if.src line
);
   import tsp_pkg::*;
   logic [1:0] scl_sync_q, scl_sync_d;
   logic [1:0] sda_sync_q, sda_sync_d;
   logic scl_last_q, scl_last_d;
   logic sda_last_q, sda_last_d;

   // ==========================================
   // next values: shift in, remember last synced level
   always_comb begin
      scl_sync_d = {scl_sync_q[0], scl_in};
      sda_sync_d = {sda_sync_q[0], sda_in};
      scl_last_d = scl_sync_q[1];
      sda_last_d = sda_sync_q[1];
   end

   // registers, idle lines read high
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_last_q <= 1'b1;
         sda_last_q <= 1'b1;
      end else begin
         scl_sync_q <= scl_sync_d;
         sda_sync_q <= sda_sync_d;
         scl_last_q <= scl_last_d;
         sda_last_q <= sda_last_d;
      end
   end

   // edge and condition detection on the second stage only
   assign line.scl_s = scl_sync_q[1];
   assign line.sda_s = sda_sync_q[1];
   assign line.scl_rise = scl_sync_q[1] & ~scl_last_q;
   assign line.scl_fall = ~scl_sync_q[1] & scl_last_q;
   assign line.start_det = scl_sync_q[1] & scl_last_q & sda_last_q &
      ~sda_sync_q[1];
   assign line.stop_det = scl_sync_q[1] & scl_last_q & ~sda_last_q &
      sda_sync_q[1];
endmodule // tsp_line_sync

// *** core/tsp_i2c_slave.sv ***
// two-wire slave port reaching eight byte registers of a flash driver
// assumes SCL and SDA pins with pull-ups, and an external reset request
module tsp_i2c_slave #(
   parameter int NUM_REGS = 8
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   output logic HS_MODE,
   output logic [tsp_pkg::TSP_DATA_W-1:0] REG_WDATA,
   output logic [tsp_pkg::TSP_REG_NUM_W-1:0] REG_WADDR,
   output logic REG_WE,
   output logic [NUM_REGS*tsp_pkg::TSP_DATA_W-1:0] REG_FILE
);
   import tsp_pkg::*;

   tsp_line_if line ();

   // ==========================================
   // pin synchroniser
   tsp_line_sync u_sync (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .scl_in(SCL_I),
      .sda_in(SDA_I),
      .line(line)
   );

   // ==========================================
   // protocol state
   tsp_state_t state_q, state_d;
   logic [TSP_BIT_CNT_W-1:0] bit_q, bit_d;
   logic [TSP_DATA_W-1:0] shift_q, shift_d;
   logic [TSP_REG_NUM_W-1:0] ptr_q, ptr_d;
   logic reg_ok_q, reg_ok_d;
   logic ack_q, ack_d;
   logic drive_q, drive_d;
   logic hs_q, hs_d;
   logic we_q, we_d;
   logic commit_q, commit_d;
   logic [TSP_DATA_W-1:0] wdata_q, wdata_d;
   logic [TSP_DATA_W-1:0] tx_q, tx_d;
   logic [TSP_DATA_W-1:0] regs_q [NUM_REGS];
   logic [TSP_DATA_W-1:0] rd_byte;
   logic [TSP_DATA_W-1:0] rx_byte;

   // received byte including the bit on this rising edge
   assign rx_byte = {shift_q[TSP_DATA_W-2:0], line.sda_s};

   // read value of the addressed register
   always_comb begin
      rd_byte = regs_q[ptr_q];
      if (!reg_ok_q) begin
         rd_byte = TSP_UNMAPPED_DATA;
      end
   end

   // next-state logic for the byte engine
   always_comb begin
      state_d = state_q;
      bit_d = bit_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      reg_ok_d = reg_ok_q;
      ack_d = ack_q;
      drive_d = drive_q;
      hs_d = hs_q;
      we_d = 1'b0;
      commit_d = commit_q;
      wdata_d = wdata_q;
      tx_d = tx_q;
      if (line.stop_det) begin
         state_d = ST_IDLE;
         drive_d = 1'b0;
         ack_d = 1'b0;
         commit_d = 1'b0;
         hs_d = 1'b0;
      end else if (line.start_det) begin
         state_d = ST_ADDR;
         bit_d = '0;
         drive_d = 1'b0;
         ack_d = 1'b0;
         commit_d = 1'b0;
      end else if (line.scl_rise) begin
         // sample on rising edge; SDA is steady while SCL high
         if (bit_q != TSP_ACK_BIT) begin
            shift_d = rx_byte;
            bit_d = bit_q + 1'b1;
         end else begin
            bit_d = '0;
            if (state_q == ST_RDATA && line.sda_s) begin
               state_d = ST_IGNORE; // master nack ends read
            end
         end
         // byte completes on the eighth rising edge
         if (bit_q == TSP_ACK_BIT - 1'b1) begin
            case (state_q)
               ST_ADDR: begin
                  if (rx_byte[7:1] == TSP_SLAVE_ADDR) begin
                     ack_d = 1'b1;
                     state_d = rx_byte[0] ? ST_RDATA : ST_REG;
                  end else begin
                     // foreign address: no ack; a code byte also switches speed
                     if (rx_byte[7:3] == TSP_HS_CODE_TOP) begin
                        hs_d = 1'b1;
                     end
                     state_d = ST_IGNORE;
                  end
               end
               ST_REG: begin
                  ptr_d = rx_byte[TSP_REG_NUM_W-1:0];
                  reg_ok_d = rx_byte[7:TSP_REG_NUM_W] == '0;
                  ack_d = 1'b1;
                  state_d = ST_WDATA;
               end
               ST_WDATA: begin
                  wdata_d = rx_byte;
                  commit_d = reg_ok_q;
                  ack_d = 1'b1;
               end
               default: begin
                  ack_d = 1'b0;
               end
            endcase
         end
      end else if (line.scl_fall) begin
         // SDA only moves while SCL low
         if (bit_q == TSP_ACK_BIT && ack_q) begin
            drive_d = 1'b1; // pull low for ack
            ack_d = 1'b0;
         end else if (bit_q == '0 && commit_q) begin
            we_d = 1'b1;
            commit_d = 1'b0;
            drive_d = 1'b0;
            ptr_d = ptr_q + 1'b1;
         end else if (state_q == ST_RDATA && bit_q != TSP_ACK_BIT) begin
            if (bit_q == '0) begin
               tx_d = {rd_byte[TSP_DATA_W-2:0], 1'b0};
               drive_d = ~rd_byte[TSP_DATA_W-1];
               ptr_d = ptr_q + 1'b1;
            end else begin
               tx_d = {tx_q[TSP_DATA_W-2:0], 1'b0};
               drive_d = ~tx_q[TSP_DATA_W-1];
            end
         end else begin
            drive_d = 1'b0; // release after ack or for master ack
         end
      end
   end

   // protocol registers
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         state_q <= ST_IDLE;
         bit_q <= '0;
         shift_q <= '0;
         ptr_q <= '0;
         reg_ok_q <= 1'b0;
         ack_q <= 1'b0;
         drive_q <= 1'b0;
         hs_q <= 1'b0;
         we_q <= 1'b0;
         commit_q <= 1'b0;
         wdata_q <= '0;
         tx_q <= '0;
      end else begin
         state_q <= state_d;
         bit_q <= bit_d;
         shift_q <= shift_d;
         ptr_q <= ptr_d;
         reg_ok_q <= reg_ok_d;
         ack_q <= ack_d;
         drive_q <= drive_d;
         hs_q <= hs_d;
         we_q <= we_d;
         commit_q <= commit_d;
         wdata_q <= wdata_d;
         tx_q <= tx_d;
      end
   end

   // ==========================================
   // register file, one entry per register number
   for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      logic [TSP_DATA_W-1:0] nxt;
      always_comb begin
         nxt = regs_q[g];
         if (we_q && REG_WADDR == TSP_REG_NUM_W'(g)) begin
            nxt = wdata_q;
         end
      end
      always_ff @(posedge REF_CLK) begin
         if (!RST_N) begin
            regs_q[g] <= TSP_REG_RESET;
         end else begin
            regs_q[g] <= nxt;
         end
      end
      assign REG_FILE[g*TSP_DATA_W +: TSP_DATA_W] = regs_q[g];
   end

   // write address is the pointer before its post-increment
   logic [TSP_REG_NUM_W-1:0] waddr_q, waddr_d;
   always_comb begin
      waddr_d = waddr_q;
      if (line.scl_fall && bit_q == '0 && commit_q) begin
         waddr_d = ptr_q;
      end
   end
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         waddr_q <= '0;
      end else begin
         waddr_q <= waddr_d;
      end
   end

   // ==========================================
   // outputs: open drain, only ever pull low
   assign SDA_O = 1'b0;
   assign SDA_OE = drive_q;
   assign HS_MODE = hs_q;
   assign REG_WDATA = wdata_q;
   assign REG_WADDR = waddr_q;
   assign REG_WE = we_q;

   // ==========================================
   // checks
   property p_stop_idle;
      @(posedge REF_CLK) disable iff (!RST_N)
      line.stop_det |=> (state_q == ST_IDLE && !SDA_OE);
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("stop did not release the bus");

   property p_stop_hs;
      @(posedge REF_CLK) disable iff (!RST_N)
      line.stop_det |=> !HS_MODE;
   endproperty
   a_stop_hs: assert property (p_stop_hs)
      else $error("high-speed mode survived a stop");

   property p_start_addr;
      @(posedge REF_CLK) disable iff (!RST_N)
      (line.start_det && !line.stop_det) |=>
         (state_q == ST_ADDR && bit_q == '0);
   endproperty
   a_start_addr: assert property (p_start_addr)
      else $error("start not detected");

   property p_no_drive_foreign;
      @(posedge REF_CLK) disable iff (!RST_N)
      (state_q == ST_IGNORE && $past(state_q) == ST_IGNORE &&
         bit_q != TSP_ACK_BIT) |-> !SDA_OE;
   endproperty
   a_no_drive_foreign: assert property (p_no_drive_foreign)
      else $error("bus driven while not addressed");

   property p_sda_stable_high;
      @(posedge REF_CLK) disable iff (!RST_N)
      (line.scl_s && $past(line.scl_s)) |-> $stable(SDA_OE);
   endproperty
   a_sda_stable_high: assert property (p_sda_stable_high)
      else $error("SDA changed while SCL high");

   property p_addr_ack;
      @(posedge REF_CLK) disable iff (!RST_N)
      (line.scl_rise && state_q == ST_ADDR && bit_q == 4'h7 &&
         rx_byte[7:1] == TSP_SLAVE_ADDR && !line.start_det &&
         !line.stop_det) |=> ack_q;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("matching address not acknowledged");

   property p_hs_code;
      @(posedge REF_CLK) disable iff (!RST_N)
      (line.scl_rise && state_q == ST_ADDR && bit_q == 4'h7 &&
         rx_byte[7:3] == TSP_HS_CODE_TOP && !line.stop_det &&
         !line.start_det) |=> (HS_MODE && !ack_q);
   endproperty
   a_hs_code: assert property (p_hs_code)
      else $error("high-speed code mishandled");

   property p_commit_fall;
      @(posedge REF_CLK) disable iff (!RST_N)
      REG_WE |-> $past(line.scl_fall) && $past(commit_q);
   endproperty
   a_commit_fall: assert property (p_commit_fall)
      else $error("write not on falling edge after ack");

   property p_ack_whole_high;
      @(posedge REF_CLK) disable iff (!RST_N)
      (bit_q == TSP_ACK_BIT && SDA_OE && line.scl_rise &&
         state_q != ST_RDATA && !line.stop_det && !line.start_det)
         |=> SDA_OE;
   endproperty
   a_ack_whole_high: assert property (p_ack_whole_high)
      else $error("acknowledge not held through high phase");
endmodule // tsp_i2c_slave

// *** tb/tsp_master_model.sv ***
// bus master model for the two-wire slave port: start, stop, bytes
// assumes an open-drain data line with a pull-up and a slave enable
module tsp_master_model (
   output logic scl,
   output wire logic sda,
   input wire logic sda_o,
   input wire logic sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic m_low;
   int half = 80;
   int unsteady;
   realtime t_fall;
   // ==========================================
   // wired data line, pull-up level when released
   assign sda = (m_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;
   // idle bus, both lines high
   initial begin
      scl = 1'b1;
      m_low = 1'b0;
   end
   // ==========================================
   // line conditions
   // start or repeated start; master makes every clock edge
   task automatic start();
      m_low = 1'b0;
      #200 scl = 1'b1;
      #160 m_low = 1'b1;
      #160 scl = 1'b0;
   endtask
   // stop releases the data line while the clock is high
   task automatic stop();
      m_low = 1'b1;
      #200 scl = 1'b1;
      #160 m_low = 1'b0;
      #160;
   endtask
   // one bit: data set in the low phase, watched over the high phase
   task automatic bit_io(input logic b, output logic r);
      #half m_low = ~b;
      #half scl = 1'b1;
      #20 r = sda;
      #120 if (sda !== r) unsteady++;
      #20 scl = 1'b0;
      t_fall = $realtime;
   endtask
   // ==========================================
   // byte transfers, msb first, ninth clock for the acknowledge
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // read a byte and answer it; a not-acknowledge ends the read
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(~ack, r);
   endtask
endmodule // tsp_master_model

// *** tb/tsp_i2c_slave_tb_top.sv ***
// self-checking bench for the two-wire slave register port
// assumes the package, design files and master model compile first
module tsp_i2c_slave_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tsp_pkg::*;
   // ==========================================
   // clock, reset and wiring
   logic ref_clk, rst_n, scl, sda, sda_o, sda_oe, hs_mode, reg_we;
   logic [7:0] reg_wdata;
   logic [2:0] reg_waddr;
   logic [63:0] reg_file;
   int errors, compares, we_cnt, oe_cnt;
   realtime t_we;
   tsp_i2c_slave u_tsp_i2c_slave (.REF_CLK(ref_clk), .RST_N(rst_n),
      .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
      .HS_MODE(hs_mode), .REG_WDATA(reg_wdata), .REG_WADDR(reg_waddr),
      .REG_WE(reg_we), .REG_FILE(reg_file));
   tsp_master_model u_tsp_master_model (.scl(scl), .sda(sda),
      .sda_o(sda_o), .sda_oe(sda_oe));
   // 25 MHz reference clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // count write pulses and slave drive cycles
   always @(posedge ref_clk) begin
      if (reg_we === 1'b1) begin
         we_cnt++;
         t_we = $realtime;
      end
      if (sda_oe === 1'b1) oe_cnt++;
   end
   // ==========================================
   // helpers
   task automatic check(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic st();
      u_tsp_master_model.start();
   endtask
   task automatic sp();
      u_tsp_master_model.stop();
   endtask
   // one byte out, acknowledge compared
   task automatic wb(input logic [7:0] d, input logic exp);
      logic a;
      u_tsp_master_model.wr_byte(d, a);
      check("ack", a, exp);
   endtask
   // one byte in, data compared
   task automatic rb(input logic ack, input logic [7:0] exp);
      logic [7:0] d;
      u_tsp_master_model.rd_byte(ack, d);
      check("read data", d, exp);
   endtask
   // ==========================================
   // scenarios
   task automatic t_write();
      realtime dt;
      st();
      wb({TSP_SLAVE_ADDR, 1'b0}, 1'b1);
      wb(8'h07, 1'b1);
      wb(8'h3C, 1'b1);
      #200;
      dt = t_we - u_tsp_master_model.t_fall;
      check("commit time", dt > 0 && dt <= 240, 1'b1);
      check("write addr", reg_waddr, 3'h7);
      check("write data", reg_wdata, 8'h3C);
      wb(8'hC3, 1'b1);
      sp();
      check("reg 7", reg_file[63:56], 8'h3C);
      check("reg 0", reg_file[7:0], 8'hC3);
      check("we count", we_cnt, 2);
      $display("test write done");
   endtask
   task automatic t_read();
      st();
      wb({TSP_SLAVE_ADDR, 1'b0}, 1'b1);
      wb(8'h07, 1'b1);
      st();
      wb({TSP_SLAVE_ADDR, 1'b1}, 1'b1);
      rb(1'b1, 8'h3C);
      rb(1'b0, 8'hC3);
      sp();
      $display("test read done");
   endtask
   task automatic t_unmapped();
      st();
      wb({TSP_SLAVE_ADDR, 1'b0}, 1'b1);
      wb(8'h1F, 1'b1);
      wb(8'h55, 1'b1);
      sp();
      check("we dropped", we_cnt, 2);
      st();
      wb({TSP_SLAVE_ADDR, 1'b0}, 1'b1);
      wb(8'h08, 1'b1);
      st();
      wb({TSP_SLAVE_ADDR, 1'b1}, 1'b1);
      rb(1'b0, TSP_UNMAPPED_DATA);
      sp();
      $display("test unmapped done");
   endtask
   task automatic t_foreign();
      logic [7:0] first [5] = '{8'h68, 8'h64, 8'hE6, 8'h00, 8'hF0};
      oe_cnt = 0;
      foreach (first[i]) begin
         st();
         wb(first[i], 1'b0);
         wb(8'h01, 1'b0);
         sp();
      end
      check("oe cycles", oe_cnt, 0);
      $display("test foreign done");
   endtask
   task automatic t_hs();
      u_tsp_master_model.half = 1170;
      st();
      wb({TSP_HS_CODE_TOP, 3'h5}, 1'b0);
      check("hs entry", hs_mode, 1'b1);
      u_tsp_master_model.half = 80;
      st();
      wb({TSP_SLAVE_ADDR, 1'b0}, 1'b1);
      wb(8'h02, 1'b1);
      wb(8'h5A, 1'b1);
      st();
      wb({TSP_SLAVE_ADDR, 1'b0}, 1'b1);
      wb(8'h02, 1'b1);
      st();
      wb({TSP_SLAVE_ADDR, 1'b1}, 1'b1);
      rb(1'b0, 8'h5A);
      check("hs kept", hs_mode, 1'b1);
      sp();
      check("hs exit", hs_mode, 1'b0);
      $display("test high speed done");
   endtask
   task automatic t_restart();
      logic r;
      st();
      wb({TSP_SLAVE_ADDR, 1'b0}, 1'b1);
      wb(8'h03, 1'b1);
      repeat (3) u_tsp_master_model.bit_io(1'b1, r);
      st();
      wb({TSP_SLAVE_ADDR, 1'b0}, 1'b1);
      wb(8'h03, 1'b1);
      wb(8'h81, 1'b1);
      sp();
      check("reg 3", reg_file[31:24], 8'h81);
      st();
      wb({TSP_SLAVE_ADDR, 1'b0}, 1'b1);
      wb(8'h04, 1'b1);
      sp();
      check("released", sda_oe, 1'b0);
      st();
      wb(8'h68, 1'b0);
      sp();
      check("reg 4", reg_file[39:32], TSP_REG_RESET);
      $display("test restart done");
   endtask
   // mid-run reset wipes a written register
   task automatic t_reset();
      st();
      wb({TSP_SLAVE_ADDR, 1'b0}, 1'b1);
      wb(8'h05, 1'b1);
      wb(8'hA5, 1'b1);
      sp();
      check("reg 5", reg_file[47:40], 8'hA5);
      @(posedge ref_clk);
      #1 rst_n = 1'b0;
      repeat (5) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      check("reset again", reg_file, {8{TSP_REG_RESET}});
      check("oe after reset", sda_oe, 1'b0);
      $display("test reset done");
   endtask
   // ==========================================
   // main sequence
   initial begin
      rst_n = 1'b0;
      repeat (5) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge ref_clk);
      // keep link edges off the clock edges
      #1;
      check("idle oe", sda_oe, 1'b0);
      check("sda value", sda_o, 1'b0);
      check("idle hs", hs_mode, 1'b0);
      check("reset regs", reg_file, {8{TSP_REG_RESET}});
      t_write();
      t_read();
      t_unmapped();
      t_foreign();
      t_hs();
      t_restart();
      t_reset();
      check("sda steady", u_tsp_master_model.unsteady, 0);
      finish_test();
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge ref_clk);
      errors++;
      finish_test();
   end
endmodule // tsp_i2c_slave_tb_top
